// ### hdl/xbu_pkg.sv
// Package of constants and types for the external bus unit.
package xbu_pkg;

  // ****************************************************************
  // Address map of the internal peripheral bus.
  // ****************************************************************
  localparam logic [23:0] XBU_CAN_BASE     = 24'h20_0000;
  localparam logic [23:0] XBU_SERIAL_BASE  = 24'h20_4000;
  localparam logic [23:0] XBU_ALT_BASE     = 24'h20_8000;
  localparam logic [23:0] XBU_CAN_MASK     = 24'hFF_C000;
  localparam logic [23:0] XBU_SERIAL_MASK  = 24'hFF_E000;
  localparam logic [23:0] XBU_ALT_MASK     = 24'hFF_C000;

  // ****************************************************************
  // Field layout of timing and function configuration words.
  // ****************************************************************
  localparam int XBU_TC_WAIT_LSB = 0;
  localparam int XBU_TC_WAIT_W   = 4;
  localparam int XBU_TC_ALE_BIT  = 4;
  localparam int XBU_FC_EN_BIT   = 0;
  localparam int XBU_FC_RDY_EN   = 1;
  localparam int XBU_FC_RDY_POL  = 2;
  localparam int XBU_FC_MUX_BIT  = 3;
  localparam int XBU_FC_W16_BIT  = 4;
  localparam logic [7:0] XBU_TC_RESET = 8'h0F;
  localparam logic [7:0] XBU_FC_RESET = 8'h19;

  // Window select: base address bits 23:16 in bits 11:4 and size code in bits 3:0 (4K << size).
  localparam int XBU_SEL_SIZE_W  = 4;

  // ****************************************************************
  // Link timing: the reference clock runs at half the system clock.
  // ****************************************************************
  localparam int XBU_CLK_DIV      = 2;
  localparam int XBU_ADDR_MAX     = 24;
  localparam int XBU_SEG_MAX      = 8;

  typedef enum logic [2:0] {
    XBU_IDLE, XBU_ADDR, XBU_WAIT, XBU_DATA, XBU_HELD
  } xbu_state_e;

endpackage

// ### hdl/xbu_window_match.sv
// Window decoder: picks the active address window with precedence.
`timescale 1ns/1ns
module xbu_window_match (
  input  wire logic [23:0]   addr,
  input  wire logic [47:0]   sel_words,
  output logic      [2:0]    win_index
);
  import xbu_pkg::*;

  // ****************************************************************
  // Window hit test.
  // ****************************************************************

  // A window covers 4 Kbytes shifted left by its size code.
  function automatic logic win_hit(input logic [23:0] a,
                                   input logic [11:0] sel);
    logic [23:0] mask;
    logic [23:0] base;
    mask = 24'hFF_F000 << sel[3:0];
    base = {sel[11:4], 16'h0000} >> 4;
    base = {sel[11:4], 4'h0, 12'h000};
    win_hit = ((a & mask) == (base & mask)) && (sel != 12'h000);
  endfunction

  // Window four beats three and two beats one; a cleared selection
  // word disables its window, leaving the default region. [RULE13]
  always_comb begin
    if (win_hit(addr, sel_words[47:36])) begin
      win_index = 3'd4;
    end else if (win_hit(addr, sel_words[35:24])) begin
      win_index = 3'd3;
    end else if (win_hit(addr, sel_words[23:12])) begin
      win_index = 3'd2;
    end else if (win_hit(addr, sel_words[11:0])) begin
      win_index = 3'd1;
    end else begin
      win_index = 3'd0; // [RULE14]
    end
  end

endmodule

// ### hdl/xbu_external_bus_unit.sv
// External bus unit: system bus to external pins and peripheral bus.
`timescale 1ns/1ns
// What this block does
// RULE1 - Single-chip mode blocks external access; external mode by config.
// RULE2 - Driven address line count is configurable from zero to 24.
// RULE3 - External data width is eight or sixteen bits.
// RULE4 - Multiplexed or demultiplexed; demux drives low address separately.
// RULE5 - Segment line count programmable; freed lines released for other use.
// RULE6 - Active-low chip selects, one per window plus default.
// RULE7 - Arbitration off until enabled; then pins handled automatically.
// RULE8 - Master role after reset; hold acknowledge is an output.
// RULE9 - Slave role makes hold acknowledge an input.
// RULE10 - Per-window timing and function configuration set bus timing.
// RULE11 - Ready input extends accesses; polarity selectable.
// RULE12 - Four address windows defined by select words.
// RULE13 - Window four beats three, window two beats one.
// RULE14 - Accesses outside windows use default configuration, index zero.
// RULE15 - Matching window asserts its chip select during the access.
// RULE16 - Bus timing referenced to rising edge of reference clock.
// RULE17 - Bus mode switches per access from the matching window.
// RULE18 - Routes CAN and serial register ranges to peripheral bus.
// RULE19 - Alternate range maps both peripheral register sets.
// RULE20 - About twelve megabytes of external memory reachable.
// RULE21 - Reference clock only with system source and pad enabled.
// RULE22 - On hold request: finish cycle, release bus, acknowledge.
module xbu_external_bus_unit (
  input  wire logic              sys_clk,
  input  wire logic              reset,
  input  wire logic              ext_bus_enable,
  input  wire logic [4:0]        addr_lines,
  input  wire logic [3:0]        seg_lines,
  input  wire logic              arb_enable,
  input  wire logic              arb_slave,
  input  wire logic              clk_src_sys,
  input  wire logic              clk_pad_enable,
  input  wire logic [47:0]       window_address_select,
  input  wire logic [39:0]       window_timing_config,
  input  wire logic [39:0]       window_function_config,
  input  wire logic              req_valid,
  input  wire logic              req_write,
  input  wire logic [23:0]       req_addr,
  input  wire logic [15:0]       req_wdata,
  output logic                   req_done,
  output logic      [15:0]       req_rdata,
  output logic                   req_error,
  output logic                   pbus_valid,
  output logic                   pbus_write,
  output logic      [23:0]       pbus_addr,
  output logic      [15:0]       pbus_wdata,
  input  wire logic              pbus_done,
  input  wire logic [15:0]       pbus_rdata,
  output logic      [23:0]       addr_out,
  output logic      [23:0]       addr_oe,
  output logic      [15:0]       ad_out,
  output logic      [15:0]       ad_oe,
  input  wire logic [15:0]       ad_in,
  output logic                   ale,
  output logic                   rd_n,
  output logic                   wr_n,
  output logic      [4:0]        cs_n,
  input  wire logic              ready_pin,
  output logic                   bus_request_out,
  output logic                   hold_acknowledge_out,
  output logic                   hold_acknowledge_oe,
  input  wire logic              hold_acknowledge_in,
  input  wire logic              hold_req_pin,
  output logic                   reference_clock_output
);
  import xbu_pkg::*;

  // ****************************************************************
  // Pin synchronisers.
  // ****************************************************************

  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;
  logic       ready_s;
  logic       hold_s;
  logic       hold_acknowledge_s;
  logic       pbus_done_s;

  // Ready, hold request and hold acknowledge pins pass two flip-flops before any logic reads them.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sync1_reg <= 4'h0;
      sync2_reg <= 4'h0;
    end else begin
      sync1_reg <= {ready_pin, hold_req_pin, hold_acknowledge_in, 1'b0};
      sync2_reg <= sync1_reg;
    end
  end
  assign ready_s     = sync2_reg[3];
  assign hold_s      = sync2_reg[2];
  assign hold_acknowledge_s      = sync2_reg[1];
  assign pbus_done_s = pbus_done;

  // ****************************************************************
  // Window decoding and per-access configuration.
  // ****************************************************************

  logic [2:0] win_now;

  xbu_window_match u_match (
    .addr      (req_addr),
    .sel_words (window_address_select),
    .win_index (win_now)
  ); // [RULE12]

  // Slot zero of the config vectors is the default region.
  function automatic logic [7:0] pick(input logic [39:0] v,
                                     input logic [2:0] i);
    pick = v[8*i +: 8];
  endfunction

  // Peripheral bus ranges, primary and alternate.
  function automatic logic is_pbus(input logic [23:0] a);
    is_pbus = ((a & XBU_CAN_MASK) == XBU_CAN_BASE)           // [RULE18]
           || ((a & XBU_SERIAL_MASK) == XBU_SERIAL_BASE)     // [RULE18]
           || ((a & XBU_ALT_MASK) == XBU_ALT_BASE);          // [RULE19]
  endfunction

  // ****************************************************************
  // Reference clock divider.
  // ****************************************************************

  logic clk_ref_reg;
  logic clk_ref_next;
  logic clk_rise;

  // The divider always runs so bus steps stay phase aligned to it.
  always_comb begin
    clk_ref_next = ~clk_ref_reg;
  end
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      clk_ref_reg <= 1'b0;
    end else begin
      clk_ref_reg <= clk_ref_next;
    end
  end
  // Bus steps advance only where the reference clock rises. [RULE16]
  assign clk_rise = ~clk_ref_reg;

  // ****************************************************************
  // Bus sequencer.
  // ****************************************************************

  xbu_state_e  state_reg,  state_next;
  logic [2:0]  win_reg,    win_next;
  logic [3:0]  wait_reg,   wait_next;
  logic [23:0] a_reg,      a_next;
  logic [15:0] wd_reg,     wd_next;
  logic        wr_reg,     wr_next;
  logic        pb_reg,     pb_next;
  logic        done_reg,   done_next;
  logic        err_reg,    err_next;
  logic [15:0] rd_reg,     rd_next;
  logic        hold_acknowledge_reg,   hold_acknowledge_next;
  logic        bus_request_out_reg,   bus_request_out_next;
  logic [7:0]  tc;
  logic [7:0]  fc;
  logic        rdy_ok;
  logic        hold_take;

  assign tc = pick(window_timing_config, win_reg);   // [RULE10]
  assign fc = pick(window_function_config, win_reg); // [RULE17]
  // Ready is sampled at the programmed polarity when enabled. [RULE11]
  assign rdy_ok = ~fc[XBU_FC_RDY_EN] | (ready_s == fc[XBU_FC_RDY_POL]);
  // Master takes hold requests; slave waits for the far acknowledge.
  assign hold_take = arb_enable & ~arb_slave & hold_s;

  // Next-state logic: one access at a time, holds only between cycles.
  always_comb begin
    state_next = state_reg;
    win_next   = win_reg;
    wait_next  = wait_reg;
    a_next     = a_reg;
    wd_next    = wd_reg;
    wr_next    = wr_reg;
    pb_next    = pb_reg;
    done_next  = 1'b0;
    err_next   = 1'b0;
    rd_next    = rd_reg;
    hold_acknowledge_next  = hold_acknowledge_reg;
    bus_request_out_next  = 1'b0;
    case (state_reg)
      XBU_IDLE: begin
        if (hold_take) begin
          state_next = XBU_HELD; // [RULE22]
        end else if (req_valid && !done_reg) begin
          a_next  = req_addr;
          wd_next = req_wdata;
          wr_next = req_write;
          win_next = win_now;
          if (is_pbus(req_addr)) begin
            pb_next    = 1'b1;
            state_next = XBU_DATA;
          end else if (!ext_bus_enable) begin
            done_next = 1'b1; // [RULE1]
            err_next  = 1'b1;
          end else if (arb_enable && arb_slave && !hold_acknowledge_s) begin
            bus_request_out_next = 1'b1; // [RULE9]
          end else begin
            pb_next    = 1'b0;
            state_next = XBU_ADDR;
          end
        end
      end
      XBU_ADDR: begin
        if (clk_rise) begin
          wait_next  = tc[XBU_TC_WAIT_LSB +: XBU_TC_WAIT_W];
          state_next = XBU_WAIT;
        end
      end
      XBU_WAIT: begin
        if (clk_rise) begin
          if (wait_reg != 4'h0) begin
            wait_next = wait_reg - 4'h1;
          end else if (rdy_ok) begin
            state_next = XBU_DATA;
          end
        end
      end
      XBU_DATA: begin
        if (pb_reg) begin
          if (pbus_done_s) begin
            rd_next    = pbus_rdata;
            done_next  = 1'b1;
            pb_next    = 1'b0;
            state_next = XBU_IDLE;
          end
        end else if (clk_rise) begin
          rd_next    = fc[XBU_FC_W16_BIT] ? ad_in : {8'h00, ad_in[7:0]};
          done_next  = 1'b1; // [RULE3]
          state_next = XBU_IDLE;
        end
      end
      XBU_HELD: begin
        hold_acknowledge_next = 1'b1;
        if (!hold_s) begin
          hold_acknowledge_next  = 1'b0;
          state_next = XBU_IDLE; // [RULE22]
        end
      end
      default: state_next = XBU_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_reg <= XBU_IDLE;
      win_reg   <= 3'd0;
      wait_reg  <= 4'h0;
      a_reg     <= 24'h00_0000;
      wd_reg    <= 16'h0000;
      wr_reg    <= 1'b0;
      pb_reg    <= 1'b0;
      done_reg  <= 1'b0;
      err_reg   <= 1'b0;
      rd_reg    <= 16'h0000;
      hold_acknowledge_reg  <= 1'b0;
      bus_request_out_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      win_reg   <= win_next;
      wait_reg  <= wait_next;
      a_reg     <= a_next;
      wd_reg    <= wd_next;
      wr_reg    <= wr_next;
      pb_reg    <= pb_next;
      done_reg  <= done_next;
      err_reg   <= err_next;
      rd_reg    <= rd_next;
      hold_acknowledge_reg  <= hold_acknowledge_next;
      bus_request_out_reg  <= bus_request_out_next;
    end
  end

  // ****************************************************************
  // Registered pin outputs.
  // ****************************************************************

  logic [23:0] amask;
  logic        on_bus;
  logic        mux;

  // Address lines beyond the programmed count are released. [RULE2]
  // Segment lines from 16+seg_lines upward are also freed. [RULE5]
  always_comb begin
    amask = 24'h00_FFFF << 0;
    for (int i = 0; i < XBU_ADDR_MAX; i++) begin // [RULE20]
      amask[i] = (i < 32'(addr_lines)) &&
                 (i < 16 || (i - 16) < 32'(seg_lines));
    end
  end
  assign on_bus = (state_reg == XBU_ADDR) || (state_reg == XBU_WAIT) ||
                  (state_reg == XBU_DATA && !pb_reg);
  assign mux = fc[XBU_FC_MUX_BIT]; // [RULE4]

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      addr_out  <= 24'h00_0000;
      addr_oe   <= 24'h00_0000;
      ad_out    <= 16'h0000;
      ad_oe     <= 16'h0000;
      ale       <= 1'b0;
      rd_n      <= 1'b1;
      wr_n      <= 1'b1;
      cs_n      <= 5'h1F;
      req_done  <= 1'b0;
      req_rdata <= 16'h0000;
      req_error <= 1'b0;
      pbus_valid <= 1'b0;
      pbus_write <= 1'b0;
      pbus_addr  <= 24'h00_0000;
      pbus_wdata <= 16'h0000;
      bus_request_out      <= 1'b0;
      hold_acknowledge_out <= 1'b0;
      hold_acknowledge_oe  <= 1'b0;
      reference_clock_output <= 1'b0;
    end else begin
      // Demux drives low address on its own lines; mux shares AD.
      addr_out <= a_reg & amask;
      addr_oe  <= on_bus ? (mux ? (amask & 24'hFF_0000) : amask)
                         : 24'h00_0000; // [RULE4]
      ad_out   <= (state_reg == XBU_ADDR && mux) ? a_reg[15:0] : wd_reg;
      ad_oe    <= (on_bus && ((state_reg == XBU_ADDR && mux) ||
                  (wr_reg && state_reg != XBU_ADDR)))
                  ? (fc[XBU_FC_W16_BIT] ? 16'hFFFF : 16'h00FF)
                  : 16'h0000;
      ale      <= on_bus && state_reg == XBU_ADDR && tc[XBU_TC_ALE_BIT];
      rd_n     <= ~(on_bus && !wr_reg && state_reg != XBU_ADDR);
      wr_n     <= ~(on_bus && wr_reg && state_reg != XBU_ADDR);
      // Only the matching window's select goes low. [RULE6] [RULE15]
      cs_n     <= (on_bus && fc[XBU_FC_EN_BIT])
                  ? ~(5'h01 << win_reg) : 5'h1F;
      req_done  <= done_next;
      req_rdata <= rd_next;
      req_error <= err_next;
      pbus_valid <= (state_next == XBU_DATA) && pb_next && !done_next;
      pbus_write <= wr_next;
      pbus_addr  <= a_next;
      pbus_wdata <= wd_next;
      bus_request_out <= bus_request_out_next & arb_enable; // [RULE7]
      // Master drives acknowledge; slave listens to it. [RULE8] [RULE9]
      hold_acknowledge_out <= hold_acknowledge_next;
      hold_acknowledge_oe  <= arb_enable & ~arb_slave;
      reference_clock_output <= clk_src_sys & clk_pad_enable &
                                clk_ref_next; // [RULE21]
    end
  end

  // ****************************************************************
  // Assertions.
  // ****************************************************************

  property p_hold_release;
    @(posedge sys_clk) disable iff (reset)
      hold_acknowledge_out |-> (addr_oe == 24'h00_0000);
  endproperty
  a_hold_release: assert property (p_hold_release) // [RULE22]
    else $error("Bus driven while hold acknowledged.");

  property p_single_chip;
    @(posedge sys_clk) disable iff (reset)
      (!ext_bus_enable && state_reg == XBU_IDLE) |=>
        (cs_n == 5'h1F) && (state_reg != XBU_ADDR);
  endproperty
  a_single_chip: assert property (p_single_chip) // [RULE1]
    else $error("Chip select active in single-chip mode.");

  property p_cs_one_hot;
    @(posedge sys_clk) disable iff (reset)
      $onehot0(~cs_n);
  endproperty
  a_cs_one_hot: assert property (p_cs_one_hot) // [RULE15]
    else $error("More than one chip select active.");

  property p_master_oe;
    @(posedge sys_clk) disable iff (reset)
      arb_slave |=> !hold_acknowledge_oe;
  endproperty
  a_master_oe: assert property (p_master_oe) // [RULE9]
    else $error("Slave role drives hold acknowledge.");

  property p_bus_request_out_off;
    @(posedge sys_clk) disable iff (reset)
      !arb_enable |=> !bus_request_out;
  endproperty
  a_bus_request_out_off: assert property (p_bus_request_out_off) // [RULE7]
    else $error("Bus request while arbitration disabled.");

  property p_refclk;
    @(posedge sys_clk) disable iff (reset)
      !(clk_src_sys && clk_pad_enable) |=> !reference_clock_output;
  endproperty
  a_refclk: assert property (p_refclk) // [RULE21]
    else $error("Reference clock without enables.");

  property p_addr_limit;
    @(posedge sys_clk) disable iff (reset)
      (addr_lines == 5'd0) |=> ##1 (addr_oe == 24'h00_0000);
  endproperty
  a_addr_limit: assert property (p_addr_limit) // [RULE2]
    else $error("Address driven with zero lines.");

  property p_ad_width;
    @(posedge sys_clk) disable iff (reset)
      (state_reg == XBU_WAIT && !fc[XBU_FC_W16_BIT]) |=>
        (ad_oe[15:8] == 8'h00);
  endproperty
  a_ad_width: assert property (p_ad_width) // [RULE3]
    else $error("Upper byte driven on 8-bit bus.");

endmodule

// ### sim/xbu_ext_memory.sv
// Behavioural model of an external memory that has a ready line.
`timescale 1ns/1ns
module xbu_ext_memory (
  input  wire logic        clk,
  input  wire logic        rd_n,
  input  wire logic        wr_n,
  input  wire logic [15:0] mem_word,
  input  wire logic [3:0]  rdy_delay,
  input  wire logic        rdy_pol,
  output logic      [15:0] ad_in,
  output logic             ready_pin
);
  // ****************************************************************
  // Data lines and access stretch counter
  // ****************************************************************
  logic [15:0] data_reg = 16'h3C3C;
  logic [3:0]  cnt_reg  = 4'h0;
  logic        idle;
  assign idle  = rd_n && wr_n;
  assign ad_in = data_reg;
  // Undriven data lines toggle every cycle, so that a stale word or a
  // read sampled too early can never pass for the right one.
  always @(posedge clk) begin
    data_reg <= rd_n ? ~data_reg : mem_word;
    cnt_reg  <= idle ? 4'h0 : cnt_reg + {3'h0, cnt_reg != 4'hF};
  end
  // Ready holds its inactive level until the access is long enough.
  assign ready_pin = (!idle && cnt_reg >= rdy_delay) ? rdy_pol
                                                     : ~rdy_pol;
endmodule

// ### sim/xbu_external_bus_unit_bench.sv
// Self-checking testbench for the external bus unit.
`timescale 1ns/1ns
module xbu_external_bus_unit_bench;
  import xbu_pkg::*;
  logic        sys_clk, reset, ext_bus_enable, arb_enable, arb_slave;
  logic        clk_src_sys, clk_pad_enable, req_valid, req_write, req_done;
  logic        req_error, pbus_valid, pbus_write, pbus_done, ale, rd_n;
  logic        wr_n, ready_pin, bus_request_out, hold_acknowledge_out;
  logic        hold_acknowledge_oe, hold_acknowledge_in, hold_req_pin;
  logic        reference_clock_output, rdy_pol;
  logic [3:0]  seg_lines, rdy_delay;
  logic [4:0]  addr_lines, cs_n, cs_seen;
  logic [15:0] req_wdata, req_rdata, pbus_wdata, pbus_rdata, ad_out, ad_oe;
  logic [15:0] ad_in, mem_word, got_w, pa;
  logic [23:0] req_addr, pbus_addr, addr_out, addr_oe, oe_seen, e, got_a;
  logic [39:0] window_timing_config, window_function_config;
  logic [47:0] window_address_select;
  logic [23:0] exp_q[$];
  logic [23:0] wa[3] = '{24'h01_0010, 24'h03_0020, 24'h05_0000};
  logic [4:0]  wcs[3] = '{5'h04, 5'h10, 5'h01};
  logic [23:0] pad[3] = '{24'h20_0000, 24'h20_4010, 24'h20_8000};
  int          n_fail, n_tests, k, n;
  integer      seed;

  xbu_external_bus_unit xbu_external_bus_unit_inst (.*);
  xbu_ext_memory xbu_ext_memory_inst (.clk(sys_clk), .rd_n(rd_n),
    .wr_n(wr_n), .mem_word(mem_word), .rdy_delay(rdy_delay),
    .rdy_pol(rdy_pol), .ad_in(ad_in), .ready_pin(ready_pin));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // One access: the note goes to the queue, then the request is held
  // until the answer; an idle edge follows so requests never merge.
  task automatic acc(input logic w, input logic [23:0] a,
                     input logic [4:0] cs, input logic err,
                     input logic [15:0] d);
    exp_q.push_back({w, ~err, err, cs, d});
    {req_write, req_addr, req_wdata, req_valid} = {w, a, d, 1'b1};
    for (k = 0; k < 400 && (req_done | req_error) !== 1'b1; k++) begin
      @(posedge sys_clk);
    end
    if (k == 400) n_fail++;
    #1 req_valid = 1'b0;
    @(posedge sys_clk);
    #1;
  endtask

  // Counts rising edges of the reference clock over sixteen cycles.
  task automatic ref_rises(output int r);
    logic p;
    r = 0;
    p = reference_clock_output;
    repeat (16) begin
      @(posedge sys_clk);
      #1;
      if (reference_clock_output === 1'b1 && p === 1'b0) r++;
      p = reference_clock_output;
    end
  endtask

  // ****************************************************************
  // Clock, monitor and peripheral bus responder
  // ****************************************************************
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // Gathers chip selects and write data while a request stands, and
  // checks each answer against the oldest note.
  always @(posedge sys_clk) begin
    if (req_valid === 1'b1) begin
      cs_seen = cs_seen | ~cs_n;
      oe_seen = oe_seen | addr_oe;
      if (wr_n === 1'b0) got_w = ad_out;
      if (ale === 1'b1) got_a = addr_out;
      if ((pbus_valid & pbus_write) === 1'b1) got_w = pbus_wdata;
    end
    if ((req_done | req_error) === 1'b1 && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      chk({e[23], req_done & ~req_error, req_error, cs_seen,
           e[22] ? (e[23] ? got_w : req_rdata) : e[15:0]}, e);
      cs_seen = 5'h00;
    end
  end

  // The peripheral side answers two cycles late, then scrambles its
  // data so that a late sample is caught.
  always @(posedge sys_clk) begin
    if (pbus_valid === 1'b1) begin
      pa = pbus_addr[15:0];
      repeat (2) @(posedge sys_clk);
      #1 pbus_rdata = pa ^ 16'hA5C3;
      pbus_done = 1'b1;
      @(posedge sys_clk);
      #1 pbus_done = 1'b0;
      pbus_rdata = ~pbus_rdata;
    end
  end

  initial begin
    #400000;
    n_fail++;
    stop_test();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    seed = 32'hA6C8_633F;
    {reset, ext_bus_enable, arb_enable, arb_slave, req_valid} = 5'h10;
    {req_write, pbus_done, hold_req_pin, hold_acknowledge_in} = 4'h0;
    {clk_src_sys, clk_pad_enable, rdy_pol, rdy_delay} = 7'h60;
    {addr_lines, seg_lines, req_addr, req_wdata} = {5'h18, 4'h8, 40'h0};
    {pbus_rdata, mem_word, got_w, cs_seen, oe_seen} = 77'h0;
    window_address_select = 48'h0340_3401_4014;
    window_timing_config = 40'h11_1111_1111;
    window_function_config = 40'h1B_1B1B_1B1B;
    repeat (2) @(posedge sys_clk);
    #1 reset = 1'b0;
    chk({cs_n, rd_n, wr_n, |addr_oe, |ad_oe}, 9'h1FC);
    acc(1'b0, 24'h01_0010, 5'h00, 1'b1, 16'h0000);
    ext_bus_enable = 1'b1;
    foreach (pad[i]) begin
      acc(1'b0, pad[i], 5'h00, 1'b0,
          pad[i][15:0] ^ 16'hA5C3);
    end
    mem_word = 16'($random(seed));
    acc(1'b1, 24'h20_4002, 5'h00, 1'b0, mem_word);
    for (int i = 0; i < 2; i++) begin
      rdy_pol = i[0];
      rdy_delay = i[0] ? 4'h6 : 4'h0;
      window_function_config = i[0] ? 40'h1F_1F1F_1F1F : 40'h1B_1B1B_1B1B;
      for (int j = 0; j < 3; j++) begin
        mem_word = 16'($random(seed));
        acc(1'b0, wa[j], wcs[j], 1'b0, mem_word);
      end
      acc(1'b1, 24'h03_0040, 5'h10, 1'b0, ~mem_word);
    end
    {rdy_pol, rdy_delay} = 5'h02;
    window_function_config = 40'h1B_1B03_1B1B;
    mem_word = 16'($random(seed));
    oe_seen = 24'h0;
    acc(1'b0, 24'h01_0010, 5'h04, 1'b0, {8'h00, mem_word[7:0]});
    chk(oe_seen[15:0], 16'hFFFF);
    acc(1'b0, 24'h03_0020, 5'h10, 1'b0, mem_word);
    {addr_lines, seg_lines, oe_seen} = {5'h0C, 4'h0, 24'h0};
    window_function_config[7:0] = 8'h13;
    acc(1'b0, 24'h0F_F120, 5'h01, 1'b0, mem_word);
    chk(oe_seen, 24'h00_0FFF);
    chk(got_a, 24'h00_0120);
    {addr_lines, seg_lines, oe_seen} = {5'h18, 4'h3, 24'h0};
    acc(1'b0, 24'h0F_F120, 5'h01, 1'b0, mem_word);
    chk(oe_seen, 24'h07_FFFF);
    // The other master asks for the bus while arbitration is still off.
    hold_req_pin = 1'b1;
    repeat (10) @(posedge sys_clk);
    #1 chk(hold_acknowledge_out, 1'b0);
    arb_enable = 1'b1;
    for (k = 0; k < 50 && hold_acknowledge_out !== 1'b1; k++) begin
      @(posedge sys_clk);
    end
    #1 chk({hold_acknowledge_out, hold_acknowledge_oe, |addr_oe, |ad_oe,
            rd_n, wr_n}, 6'h33);
    hold_req_pin = 1'b0;
    repeat (8) @(posedge sys_clk);
    #1 chk(hold_acknowledge_out, 1'b0);
    arb_slave = 1'b1;
    repeat (4) @(posedge sys_clk);
    #1 chk(hold_acknowledge_oe, 1'b0);
    // A slave asks for the bus until the far master acknowledges.
    {addr_lines, oe_seen} = {5'h00, 24'h0};
    {req_write, req_addr, req_valid} = {1'b0, 24'h01_0010, 1'b1};
    repeat (6) @(posedge sys_clk);
    #1 chk({bus_request_out, req_done}, 2'h2);
    hold_acknowledge_in = 1'b1;
    acc(1'b0, 24'h01_0010, 5'h04, 1'b0, {8'h00, mem_word[7:0]});
    chk(oe_seen, 24'h00_0000);
    {arb_slave, arb_enable} = 2'h0;
    ref_rises(n);
    chk(n, 16 / XBU_CLK_DIV);
    for (int i = 0; i < 2; i++) begin
      {clk_src_sys, clk_pad_enable} = i[0] ? 2'h1 : 2'h2;
      repeat (2) @(posedge sys_clk);
      ref_rises(n);
      chk({n[4:0], reference_clock_output}, 6'h00);
    end
    stop_test();
  end
endmodule
